// file: core/crs_pkg.sv
// package: constants and carriers of the cpu register set
package crs_pkg;

  localparam int CRS_XLEN = 32;
  localparam int CRS_NUM_GPR = 16;
  localparam logic [3:0] CRS_IDX_INDEX = 4'h0;
  localparam logic [3:0] CRS_IDX_STACK = 4'hf;
  localparam logic [31:0] CRS_INSTR_BYTES = 32'h0000_0002;
  localparam logic [31:0] CRS_LONG_BYTES = 32'h0000_0004;
  localparam logic [31:0] CRS_FRAME_BYTES = 32'h0000_0008;

  // register bus byte offsets, one aligned word each
  localparam logic [7:0] CRS_OFF_GPR0 = 8'h00;
  localparam logic [7:0] CRS_OFF_STATUS_WORD = 8'h40;
  localparam logic [7:0] CRS_OFF_GLOBAL_BASE = 8'h44;
  localparam logic [7:0] CRS_OFF_VECTOR_BASE = 8'h48;
  localparam logic [7:0] CRS_OFF_MAC_HIGH = 8'h4c;
  localparam logic [7:0] CRS_OFF_MAC_LOW = 8'h50;
  localparam logic [7:0] CRS_OFF_RETURN_LINK = 8'h54;
  localparam logic [7:0] CRS_OFF_PROGRAM_COUNTER = 8'h58;
  localparam logic [7:0] CRS_OFF_FAULT = 8'h5c;

  // status_word fields
  localparam int CRS_SR_T_POS = 0;
  localparam int CRS_SR_S_POS = 1;
  localparam int CRS_SR_IMASK_LSB = 4;
  localparam int CRS_SR_IMASK_MSB = 7;
  localparam int CRS_SR_Q_POS = 8;
  localparam int CRS_SR_M_POS = 9;
  localparam logic [31:0] CRS_SR_IMPL_MASK = 32'h0000_03f3;
  localparam logic [31:0] CRS_SR_RESET = 32'h0000_00f0;
  localparam logic [31:0] CRS_VBR_RESET = 32'h0000_0000;
  localparam logic [31:0] CRS_UNDEF_RESET = 32'h0000_0000;

  // fault register field
  localparam int CRS_FAULT_ADDR_ERR_POS = 0;

  // timing
  localparam int CRS_CLK_PERIOD_NS = 40;
  localparam int CRS_INSTR_TIME_NS = 50;
  localparam int CRS_INSTR_REF_MHZ = 20;
  localparam int CRS_INSTR_CYCLES = 1;

  typedef enum logic [1:0] {
    CRS_SZ_BYTE,
    CRS_SZ_WORD,
    CRS_SZ_LONG
  } crs_size_type;

  typedef enum logic [1:0] {
    CRS_WB_ALU,
    CRS_WB_LOAD,
    CRS_WB_IMM_ARITH,
    CRS_WB_IMM_LOGIC
  } crs_wb_src_type;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    crs_wb_src_type src;
    crs_size_type size;
    logic [31:0] data;
  } crs_wb_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    crs_size_type size;
    logic stack;
  } crs_mem_type;

  typedef struct packed {
    logic valid;
    logic call;
    logic [31:0] target;
  } crs_branch_type;

  typedef struct packed {
    logic valid;
    logic [31:0] sp;
    logic [31:0] pc;
  } crs_vec_type;

endpackage

// file: core/crs_extend.sv
// extends a loaded value or an 8-bit immediate to a 32-bit operand
`timescale 1ns/100ps
`default_nettype none
module crs_extend
  import crs_pkg::*;
(
  input wire crs_pkg::crs_wb_src_type src,
  input wire crs_pkg::crs_size_type size,
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  always_comb
  begin
    dout = din;
    unique case (src)
      CRS_WB_LOAD:
      begin
        if (size == CRS_SZ_BYTE)
          dout = {{24{din[7]}}, din[7:0]};
        else if (size == CRS_SZ_WORD)
          dout = {{16{din[15]}}, din[15:0]};
      end
      CRS_WB_IMM_ARITH: dout = {{24{din[7]}}, din[7:0]};
      CRS_WB_IMM_LOGIC: dout = {24'h00_0000, din[7:0]};
      CRS_WB_ALU: dout = din;
    endcase
  end
endmodule
`default_nettype wire

// file: core/crs_align.sv
// flags misaligned memory and stack accesses
`timescale 1ns/100ps
`default_nettype none
module crs_align
  import crs_pkg::*;
(
  input wire crs_pkg::crs_mem_type req,
  output logic err
);
  always_comb
  begin
    err = 1'b0;
    if (req.valid)
    begin
      // stack slots hold long words only
      if (req.stack && req.size != CRS_SZ_LONG)
        err = 1'b1;
      else if (req.size == CRS_SZ_WORD)
        err = req.addr[0];
      else if (req.size == CRS_SZ_LONG)
        err = |req.addr[1:0];
    end
  end
endmodule
`default_nettype wire

// file: core/crs_regset.sv
// architectural register set with operand formatting and pc control
//
// Overview of operation
// - sixteen general, three control, four system registers
// - index_register offsets indexed and base addressing
// - stack_register pushes and pops exception frames
// - global_base gives peripheral base address
// - vector_base gives exception vector area base
// - mac_high and mac_low hold multiply results
// - call saves return_link; program_counter steers fetch
// - reset: mask bits ones, vector_base zero
// - stack_register and program_counter load from vectors
// - loaded bytes and words sign-extend to 32
// - byte accesses off the stack never fault on alignment
// - misaligned word or long raises address error
// - stack accesses must be aligned long words
// - arithmetic immediates sign-extend from eight bits
// - logical immediates zero-extend from eight bits
// - wide constants fetched pc-relative from memory
// - instructions are fixed sixteen bits
// - one basic instruction per clock
// - arithmetic between registers; bit ops on memory
// - unconditional branch runs its delay slot first
// - long word is the standard operand length
`timescale 1ns/100ps
`default_nettype none
module crs_regset
  import crs_pkg::*;
#(
  parameter int XLEN = CRS_XLEN,
  parameter int NUM_GPR = CRS_NUM_GPR
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  output logic [XLEN-1:0] rd_a_data,
  output logic [XLEN-1:0] rd_b_data,
  input wire crs_pkg::crs_wb_type wb,
  input wire crs_pkg::crs_mem_type mem_req,
  output logic mem_ok,
  output logic addr_err,
  input wire crs_pkg::crs_vec_type vec_load,
  input wire logic instr_step,
  input wire crs_pkg::crs_branch_type branch,
  input wire logic exc_push,
  input wire logic exc_pop,
  input wire logic mac_wr,
  input wire logic [2*XLEN-1:0] mac_value,
  input wire logic [7:0] vec_num,
  input wire logic [7:0] lit_disp,
  input wire logic lit_long,
  input wire logic [7:0] gbr_disp,
  output logic [31:0] fetch_addr,
  output logic [31:0] stack_addr,
  output logic [31:0] index_addr,
  output logic [31:0] gbr_addr,
  output logic [31:0] vector_addr,
  output logic [31:0] literal_addr,
  output logic [31:0] status_out,
  output logic [31:0] return_out,
  output logic [2*XLEN-1:0] mac_out,
  output logic delay_slot
);
  import crs_pkg::*;

  logic [XLEN-1:0] gpr_r [NUM_GPR];
  logic [31:0] status_word_r;
  logic [31:0] global_base_r;
  logic [31:0] vector_base_r;
  logic [31:0] mac_high_r;
  logic [31:0] mac_low_r;
  logic [31:0] return_link_r;
  logic [31:0] program_counter_r;
  logic [31:0] target_r;
  logic pend_r;
  logic fault_r;
  logic [31:0] wb_ext;
  logic misalign;
  logic bus_gpr;
  logic [3:0] bus_idx;
  logic [31:0] rdata_nxt;
  logic [31:0] sp_nxt;

  // operand formatting for all writebacks
  crs_extend u_extend (
    .src(wb.src),
    .size(wb.size),
    .din(wb.data),
    .dout(wb_ext)
  );

  crs_align u_align (
    .req(mem_req),
    .err(misalign)
  );

  assign bus_gpr = (reg_addr < CRS_OFF_STATUS_WORD) && (reg_addr[1:0] == 2'b00);
  assign bus_idx = reg_addr[5:2];

  // stack pointer movement on exception entry and return
  always_comb
  begin
    sp_nxt = gpr_r[CRS_IDX_STACK];
    if (exc_push)
      sp_nxt = gpr_r[CRS_IDX_STACK] - CRS_FRAME_BYTES;
    else if (exc_pop)
      sp_nxt = gpr_r[CRS_IDX_STACK] + CRS_FRAME_BYTES;
  end

  // general registers: core writeback wins over the bus
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_GPR; i++)
        gpr_r[i] <= CRS_UNDEF_RESET;
    end
    else
    begin
      if (reg_wr && bus_gpr)
        gpr_r[bus_idx] <= reg_wdata;
      if (exc_push || exc_pop)
        gpr_r[CRS_IDX_STACK] <= sp_nxt;
      if (wb.en)
        gpr_r[wb.idx] <= wb_ext;
      if (vec_load.valid)
        gpr_r[CRS_IDX_STACK] <= vec_load.sp;
    end
  end

  // status word; reserved bits forced to zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      status_word_r <= CRS_SR_RESET;
    else if (reg_wr && reg_addr == CRS_OFF_STATUS_WORD)
      status_word_r <= reg_wdata & CRS_SR_IMPL_MASK;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      global_base_r <= CRS_UNDEF_RESET;
    else if (reg_wr && reg_addr == CRS_OFF_GLOBAL_BASE)
      global_base_r <= reg_wdata;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      vector_base_r <= CRS_VBR_RESET;
    else if (reg_wr && reg_addr == CRS_OFF_VECTOR_BASE)
      vector_base_r <= reg_wdata;
  end

  // multiply-accumulate pair; core result wins over the bus
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mac_high_r <= CRS_UNDEF_RESET;
      mac_low_r <= CRS_UNDEF_RESET;
    end
    else if (mac_wr)
    begin
      mac_high_r <= mac_value[2*XLEN-1:XLEN];
      mac_low_r <= mac_value[XLEN-1:0];
    end
    else if (reg_wr && reg_addr == CRS_OFF_MAC_HIGH)
      mac_high_r <= reg_wdata;
    else if (reg_wr && reg_addr == CRS_OFF_MAC_LOW)
      mac_low_r <= reg_wdata;
  end

  // return address is past the delay slot
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      return_link_r <= CRS_UNDEF_RESET;
    else if (branch.valid && branch.call)
      return_link_r <= program_counter_r + (CRS_INSTR_BYTES << 1);
    else if (reg_wr && reg_addr == CRS_OFF_RETURN_LINK)
      return_link_r <= reg_wdata;
  end

  // delayed branch bookkeeping
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_r <= 1'b0;
      target_r <= CRS_UNDEF_RESET;
    end
    else if (vec_load.valid)
      pend_r <= 1'b0;
    else if (branch.valid)
    begin
      pend_r <= 1'b1;
      target_r <= branch.target;
    end
    else if (instr_step && pend_r)
      pend_r <= 1'b0;
  end

  // one fixed-length instruction per step
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      program_counter_r <= CRS_UNDEF_RESET;
    else if (vec_load.valid)
      program_counter_r <= vec_load.pc;
    else if (instr_step && pend_r)
      program_counter_r <= target_r;
    else if (instr_step)
      program_counter_r <= program_counter_r + CRS_INSTR_BYTES;
    else if (reg_wr && reg_addr == CRS_OFF_PROGRAM_COUNTER)
      program_counter_r <= reg_wdata;
  end

  // sticky address error; a new error beats the clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      fault_r <= 1'b0;
    else if (misalign)
      fault_r <= 1'b1;
    else if (reg_wr && reg_addr == CRS_OFF_FAULT &&
             reg_wdata[CRS_FAULT_ADDR_ERR_POS])
      fault_r <= 1'b0;
  end

  // memory check result, one cycle after the request
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_err <= 1'b0;
      mem_ok <= 1'b0;
    end
    else
    begin
      addr_err <= misalign;
      mem_ok <= mem_req.valid && !misalign;
    end
  end

  // register bus read
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (bus_gpr)
      rdata_nxt = gpr_r[bus_idx];
    else
    begin
      unique case (reg_addr)
        CRS_OFF_STATUS_WORD: rdata_nxt = status_word_r;
        CRS_OFF_GLOBAL_BASE: rdata_nxt = global_base_r;
        CRS_OFF_VECTOR_BASE: rdata_nxt = vector_base_r;
        CRS_OFF_MAC_HIGH: rdata_nxt = mac_high_r;
        CRS_OFF_MAC_LOW: rdata_nxt = mac_low_r;
        CRS_OFF_RETURN_LINK: rdata_nxt = return_link_r;
        CRS_OFF_PROGRAM_COUNTER: rdata_nxt = program_counter_r;
        CRS_OFF_FAULT: rdata_nxt = {31'h0000_0000, fault_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 32'h0000_0000;
  end

  // operand read ports
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else
    begin
      rd_a_data <= gpr_r[rd_a_idx];
      rd_b_data <= gpr_r[rd_b_idx];
    end
  end

  // derived addresses
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fetch_addr <= 32'h0000_0000;
      stack_addr <= 32'h0000_0000;
      index_addr <= 32'h0000_0000;
      gbr_addr <= 32'h0000_0000;
      vector_addr <= 32'h0000_0000;
      literal_addr <= 32'h0000_0000;
    end
    else
    begin
      fetch_addr <= program_counter_r;
      stack_addr <= gpr_r[CRS_IDX_STACK];
      index_addr <= global_base_r + gpr_r[CRS_IDX_INDEX];
      gbr_addr <= global_base_r + {24'h00_0000, gbr_disp};
      vector_addr <= vector_base_r + {22'h00_0000, vec_num, 2'b00};
      if (lit_long)
        literal_addr <= (program_counter_r & 32'hffff_fffc) +
                        {22'h00_0000, lit_disp, 2'b00};
      else
        literal_addr <= program_counter_r +
                        {23'h00_0000, lit_disp, 1'b0};
    end
  end

  // visible system state
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_out <= CRS_SR_RESET;
      return_out <= CRS_UNDEF_RESET;
      mac_out <= '0;
      delay_slot <= 1'b0;
    end
    else
    begin
      status_out <= status_word_r;
      return_out <= return_link_r;
      mac_out <= {mac_high_r, mac_low_r};
      delay_slot <= pend_r;
    end
  end

endmodule
`default_nettype wire

// file: dv/crs_vec_table.sv
// model: vector address table that loads sp and pc after reset
`timescale 1ns/100ps
`default_nettype none
module crs_vec_table
  import crs_pkg::*;
#(
  parameter logic [31:0] SP_INIT = 32'h0000_2000,
  parameter logic [31:0] PC_INIT = 32'h0000_0100
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  output crs_pkg::crs_vec_type vec_load
);
  logic done_r;
  // one load pulse, then the table words go stale
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      done_r <= 1'b0;
      vec_load <= '0;
    end
    else
    begin
      done_r <= 1'b1;
      vec_load.valid <= !done_r;
      vec_load.sp <= done_r ? ~SP_INIT : SP_INIT;
      vec_load.pc <= done_r ? ~PC_INIT : PC_INIT;
    end
endmodule
`default_nettype wire

// file: dv/crs_regset_assertions.sv
// checker: alignment, pc, stack and mac relations at the ports
`timescale 1ns/100ps
`default_nettype none
module crs_regset_assertions
  import crs_pkg::*;
#(
  parameter int XLEN = CRS_XLEN
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire crs_pkg::crs_mem_type mem_req,
  input wire logic mem_ok,
  input wire logic addr_err,
  input wire crs_pkg::crs_vec_type vec_load,
  input wire logic instr_step,
  input wire crs_pkg::crs_branch_type branch,
  input wire logic exc_push,
  input wire crs_pkg::crs_wb_type wb,
  input wire logic mac_wr,
  input wire logic [2*XLEN-1:0] mac_value,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] stack_addr,
  input wire logic [31:0] return_out,
  input wire logic [2*XLEN-1:0] mac_out,
  input wire logic delay_slot
);
  logic [31:0] tgt_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      tgt_r <= '0;
    else if (branch.valid)
      tgt_r <= branch.target;
  sequence s_take_branch;
    branch.valid && instr_step && !delay_slot && !vec_load.valid;
  endsequence
  // the step right after a taken branch retires the slot and jumps
  sequence s_run_slot;
    s_take_branch ##1 (instr_step && !branch.valid && !vec_load.valid);
  endsequence
  a_word_misalign: assert property (
    mem_req.valid && mem_req.size == CRS_SZ_WORD && mem_req.addr[0]
    |=> addr_err && !mem_ok) else $error("odd word not flagged");
  a_long_misalign: assert property (
    mem_req.valid && mem_req.size == CRS_SZ_LONG && mem_req.addr[1:0] != 0
    |=> addr_err) else $error("unaligned long not flagged");
  a_byte_free: assert property (
    mem_req.valid && mem_req.size == CRS_SZ_BYTE && !mem_req.stack
    |=> mem_ok && !addr_err) else $error("byte access refused");
  a_stack_long: assert property (
    mem_req.valid && mem_req.stack && mem_req.size != CRS_SZ_LONG
    |=> addr_err && !mem_ok) else $error("short stack access passed");
  a_pc_step: assert property (
    instr_step && !branch.valid && !vec_load.valid && !delay_slot
    && !$past(branch.valid)
    |-> ##2 fetch_addr == $past(fetch_addr) + CRS_INSTR_BYTES)
    else $error("pc step wrong");
  a_branch_pend: assert property (
    s_take_branch |-> ##2 delay_slot) else $error("no slot after branch");
  a_slot_target: assert property (
    s_run_slot |-> ##2 fetch_addr == $past(tgt_r, 2))
    else $error("slot did not reach target");
  a_call_link: assert property (
    s_take_branch ##0 branch.call
    |-> ##2 return_out == $past(fetch_addr) + CRS_LONG_BYTES)
    else $error("return link wrong");
  a_vec_init: assert property (
    vec_load.valid |-> ##2 fetch_addr == $past(vec_load.pc, 2)
    && stack_addr == $past(vec_load.sp, 2)) else $error("vector load wrong");
  a_frame_push: assert property (
    exc_push && !vec_load.valid && !(wb.en && wb.idx == CRS_IDX_STACK)
    |-> ##2 stack_addr == $past(stack_addr) - CRS_FRAME_BYTES)
    else $error("push step wrong");
  a_mac_hold: assert property (
    mac_wr |-> ##2 mac_out == $past(mac_value, 2)) else $error("mac wrong");
endmodule
bind crs_regset crs_regset_assertions #(.XLEN(XLEN)) u_chk (
  .clk_sys, .arst_n, .mem_req, .mem_ok, .addr_err, .vec_load, .instr_step,
  .branch, .exc_push, .wb, .mac_wr, .mac_value, .fetch_addr, .stack_addr,
  .return_out, .mac_out, .delay_slot
);
`default_nettype wire

// file: dv/tb.sv
// testbench: register bus, operand format, alignment, branch and stack
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module tb;
  import crs_pkg::*;
  localparam logic [31:0] SPV = 32'h0000_2000;
  localparam logic [31:0] PCV = 32'h0000_0100;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = '0, vec_num = '0, lit_disp = 8'h05, gbr_disp = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, instr_step = 1'b0, mac_wr = 1'b0;
  logic exc_push = 1'b0, exc_pop = 1'b0, lit_long = 1'b0;
  logic [3:0] rd_a_idx = '0;
  logic [63:0] mac_value = '0, mac_out;
  crs_wb_type wb = '0;
  crs_mem_type mem_req = '0;
  crs_branch_type branch = '0;
  crs_vec_type vec_load;
  logic [31:0] reg_rdata, rd_a_data, rd_b_data, fetch_addr, stack_addr;
  logic [31:0] index_addr;
  logic [31:0] gbr_addr, vector_addr, literal_addr, status_out, return_out;
  logic mem_ok, addr_err, delay_slot;
  int err_total = 0;
  int cmp_count = 0;
  always #20 clk_sys = ~clk_sys;
  crs_vec_table #(.SP_INIT(SPV), .PC_INIT(PCV)) u_vt (
    .clk_sys, .arst_n, .vec_load);
  crs_regset uut (
    .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rd_a_idx, .rd_b_idx(rd_a_idx), .rd_a_data, .rd_b_data, .wb, .mem_req,
    .mem_ok, .addr_err, .vec_load, .instr_step, .branch, .exc_push, .exc_pop,
    .mac_wr, .mac_value, .vec_num, .lit_disp, .lit_long, .gbr_disp,
    .fetch_addr, .stack_addr, .index_addr, .gbr_addr, .vector_addr,
    .literal_addr, .status_out, .return_out, .mac_out, .delay_slot);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic wbc(input crs_wb_src_type s, input crs_size_type z,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_sys);
    wb <= '{1'b1, 4'h3, s, z, d};
    rd_a_idx <= 4'h3;
    @(posedge clk_sys);
    wb.en <= 1'b0;
    @(posedge clk_sys);
    #1 `CHK(rd_a_data, e)
    `CHK(rd_b_data, e)
  endtask
  task automatic mc(input logic [31:0] a, input crs_size_type z,
                    input logic s, input logic e);
    @(posedge clk_sys);
    mem_req <= '{1'b1, a, z, s};
    @(posedge clk_sys);
    mem_req.valid <= 1'b0;
    #1 `CHK({addr_err, mem_ok}, {e, !e})
  endtask
  task automatic lit(input logic l, input logic [31:0] e);
    @(posedge clk_sys);
    lit_long <= l;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(literal_addr, e)
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    `CHK(status_out, 32'h0000_00f0)
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'h40, 32'h0000_00f0);
    rd(8'h48, 32'h0000_0000);
    rd(8'h3c, SPV);
    rd(8'h58, PCV);
    rd(8'h60, 32'h0000_0000);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0000_03f3);
    `CHK(status_out, 32'h0000_03f3)
    for (int i = 1; i < 15; i++)
    begin
      wr(8'(4 * i), {8{4'(i)}});
      rd(8'(4 * i), {8{4'(i)}});
    end
    wr(8'h00, 32'h0000_0010);
    wr(8'h44, 32'h0000_1000);
    wr(8'h48, 32'h0000_0400);
    @(posedge clk_sys);
    gbr_disp <= 8'h20;
    vec_num <= 8'h03;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(index_addr, 32'h0000_1010)
    `CHK(gbr_addr, 32'h0000_1020)
    `CHK(vector_addr, 32'h0000_040c)
    wbc(CRS_WB_LOAD, CRS_SZ_BYTE, 32'h0000_0080, 32'hffff_ff80);
    wbc(CRS_WB_LOAD, CRS_SZ_WORD, 32'h0000_8001, 32'hffff_8001);
    wbc(CRS_WB_LOAD, CRS_SZ_WORD, 32'h0000_1234, 32'h0000_1234);
    wbc(CRS_WB_LOAD, CRS_SZ_LONG, 32'h8000_0000, 32'h8000_0000);
    wbc(CRS_WB_IMM_ARITH, CRS_SZ_BYTE, 32'h0000_00ff, 32'hffff_ffff);
    wbc(CRS_WB_IMM_ARITH, CRS_SZ_BYTE, 32'h0000_007f, 32'h0000_007f);
    wbc(CRS_WB_IMM_LOGIC, CRS_SZ_BYTE, 32'habcd_12ff, 32'h0000_00ff);
    wbc(CRS_WB_ALU, CRS_SZ_LONG, 32'hdead_beef, 32'hdead_beef);
    @(posedge clk_sys);
    mac_wr <= 1'b1;
    mac_value <= 64'h1234_5678_9abc_def0;
    @(posedge clk_sys);
    mac_wr <= 1'b0;
    rd(8'h4c, 32'h1234_5678);
    rd(8'h50, 32'h9abc_def0);
    mc(32'h0000_1003, CRS_SZ_BYTE, 1'b0, 1'b0);
    mc(32'h0000_1001, CRS_SZ_WORD, 1'b0, 1'b1);
    mc(32'h0000_1002, CRS_SZ_WORD, 1'b0, 1'b0);
    mc(32'h0000_1002, CRS_SZ_LONG, 1'b0, 1'b1);
    mc(32'h0000_1004, CRS_SZ_LONG, 1'b0, 1'b0);
    mc(32'h0000_1002, CRS_SZ_WORD, 1'b1, 1'b1);
    mc(32'h0000_1004, CRS_SZ_LONG, 1'b1, 1'b0);
    rd(8'h5c, 32'h0000_0001);
    wr(8'h5c, 32'h0000_0001);
    rd(8'h5c, 32'h0000_0000);
    @(posedge clk_sys);
    exc_push <= 1'b1;
    @(posedge clk_sys);
    exc_push <= 1'b0;
    rd(8'h3c, SPV - CRS_FRAME_BYTES);
    @(posedge clk_sys);
    exc_pop <= 1'b1;
    @(posedge clk_sys);
    exc_pop <= 1'b0;
    rd(8'h3c, SPV);
    @(posedge clk_sys);
    instr_step <= 1'b1;
    @(posedge clk_sys);
    branch <= '{1'b1, 1'b1, 32'h0000_0200};
    @(posedge clk_sys);
    branch.valid <= 1'b0;
    #1 `CHK(delay_slot, 1'b0)
    @(posedge clk_sys);
    instr_step <= 1'b0;
    #1 `CHK(delay_slot, 1'b1)
    rd(8'h58, 32'h0000_0200);
    rd(8'h54, PCV + 32'h0000_0006);
    `CHK(fetch_addr, 32'h0000_0200)
    lit(1'b1, 32'h0000_0214);
    lit(1'b0, 32'h0000_020a);
    close_out();
  end
endmodule
`default_nettype wire
